/* File: design/power_seq_defines.vh */
// Constants for the sideband power sequencer: offsets, fields, resets, timings
`ifndef POWER_SEQ_DEFINES_VH
`define POWER_SEQ_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_POLICY 8'h00
`define OFF_MGMT 8'h04
`define OFF_SLEEP 8'h08
`define OFF_RESET 8'h0C
`define OFF_STATUS 8'h10

// ----------------------------------------------------------------
// Policy register fields (RTC-backed)
// ----------------------------------------------------------------
`define POL_AFTER_G3 0
`define POL_SLEEP_LAN 1
`define POL_BATT_DIS 2
`define POL_HOST_WW 3
`define POL_GPIO_MODE 4
`define POL_GPIO_DIR 5
`define POL_GPIO_DATA 6
`define POL_WIDTH 7
`define POL_RESET 7'h00

// ----------------------------------------------------------------
// Management register fields
// ----------------------------------------------------------------
`define MG_WL_ACCESS 0
`define MG_LAN_KEEP 1
`define MG_ACK_AC 2
`define MG_ACK_DC 3
`define MG_WIDTH 4
`define MG_RESET 4'h0

// ----------------------------------------------------------------
// Sleep, reset command and status fields
// ----------------------------------------------------------------
`define SL_TGT_LO 0
`define SL_TGT_HI 1
`define SL_MGMT_ON 2
`define SL_GO 3
`define TGT_S3 2'h0
`define TGT_S4 2'h1
`define TGT_S5 2'h2
`define TGT_RESET 2'h2
`define RC_HOST 0
`define RC_CYCLE 1
`define RC_GLOBAL 2
`define RC_S5 3
`define ST_STATE_LO 0
`define ST_STATE_HI 5
`define ST_BATT_LOW 6
`define ST_SMI 7
`define ST_TIMEOUT 8
`define ST_IN_G3 9
`define ST_GPIO_IN 10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 100000000
`define ACK_TIMEOUT_S 4
`define PWR_CYCLE_MS 5
`define ACK_TIMEOUT_CYC (`ACK_TIMEOUT_S * `CLK_HZ)
`define PWR_CYCLE_CYC (`PWR_CYCLE_MS * (`CLK_HZ / 1000))

`endif

/* File: design/sync_bus.v */
// Two-flop synchroniser for a bus of independent level inputs
`timescale 1ns/100ps
`default_nettype none

module sync_bus #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire clk_i,
	input wire rst_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	genvar g;

	// ----------------------------------------------------------------
	// One chain per bit; the first stage feeds only the second
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : chain
			reg meta_reg;
			reg stable_reg;
			always @(posedge clk_i) begin
				if (rst_i) begin
					meta_reg <= INIT[g];
					stable_reg <= INIT[g];
				end else begin
					meta_reg <= async_i[g];
					stable_reg <= meta_reg;
				end
			end
			assign sync_o[g] = stable_reg;
		end
	endgenerate

endmodule
`default_nettype wire

/* File: design/shared_pin_mux.v */
// Output stage of the pin shared by power-down acknowledge and a GPIO
`timescale 1ns/100ps
`default_nettype none

module shared_pin_mux (
	input wire clk_i,
	input wire rst_i,
	input wire gpio_mode_i,
	input wire gpio_direction_select_i,
	input wire gpio_data_i,
	input wire native_value_i,
	output reg pin_o,
	output reg pin_oe_o
);

	// ----------------------------------------------------------------
	// Native drives the acknowledge, GPIO input floats, GPIO out drives
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b1;
		end else if (!gpio_mode_i) begin
			pin_o <= native_value_i;
			pin_oe_o <= 1'b1;
		end else if (gpio_direction_select_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o <= gpio_data_i;
			pin_oe_o <= 1'b1;
		end
	end

endmodule
`default_nettype wire

/* File: design/power_seq.v */
// Sideband power sequencer: sleep outputs, PHY gates, acknowledge pin, reset flows
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_defines.vh"

module power_seq #(
	parameter [31:0] ACK_TIMEOUT_CYC = `ACK_TIMEOUT_CYC,
	parameter [31:0] PWR_CYCLE_CYC = `PWR_CYCLE_CYC
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire battery_low_n_i,
	input wire platform_power_good_i,
	input wire system_reset_button_n_i,
	input wire rtc_well_reset_n_i,
	input wire secondary_rtc_reset_n_i,
	input wire on_battery_i,
	input wire wake_event_i,
	input wire proc_c10_entry_i,
	input wire mem_safe_i,
	input wire reset_ack_i,
	input wire shared_gpio_pin_i,
	output reg sleep_s3_out_n_o,
	output reg sleep_s4_out_n_o,
	output reg sleep_s5_out_n_o,
	output reg mgmt_sleep_out_n_o,
	output reg wired_phy_power_gate_n_o,
	output reg wireless_phy_power_gate_n_o,
	output reg deep_idle_gate_n_o,
	output reg platform_reset_n_o,
	output reg system_mgmt_interrupt_o,
	output reg mem_flush_req_o,
	output wire shared_gpio_pin_o,
	output wire shared_gpio_pin_oe_o
);

	// ----------------------------------------------------------------
	// States, one-hot
	// ----------------------------------------------------------------
	localparam [5:0] ST_S0 = 6'h01;
	localparam [5:0] ST_SX = 6'h02;
	localparam [5:0] ST_DRAIN = 6'h04;
	localparam [5:0] ST_ACKW = 6'h08;
	localparam [5:0] ST_CYCLE = 6'h10;
	localparam [5:0] ST_S5 = 6'h20;

	// Register decode, used by both the write and the read path
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:2] == off[7:2]);
		end
	endfunction

	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg [31:0] cnt_reg;
	reg [`POL_WIDTH-1:0] policy_reg;
	reg [`MG_WIDTH-1:0] mgmt_reg;
	reg [1:0] target_reg;
	reg mgmt_on_reg;
	reg kind_cycle_reg;
	reg kind_s5_reg;
	reg in_g3_reg;
	reg smi_reg;
	reg timeout_reg;
	reg batt_low_prev_reg;
	reg button_prev_reg;
	reg ack_value_reg;
	wire [2:0] sync_out;
	wire batt_low;
	wire button_n;
	wire power_good_s;
	wire access;
	wire wr;
	wire wr_sleep_go;
	wire wr_reset;
	wire any_trig;
	wire trig_cycle;
	wire trig_global;
	wire trig_s5;
	wire wake_ok;
	wire timed_out;
	wire cycle_done;
	wire batt_low_rise;
	wire in_reset_state;
	wire sx_mgmt_off;
	reg [31:0] rd_data;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	sync_bus #(
		.WIDTH(3),
		.INIT(3'h7)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({platform_power_good_i, system_reset_button_n_i, battery_low_n_i}),
		.sync_o(sync_out)
	);
	assign batt_low = ~sync_out[0];
	assign button_n = sync_out[1];
	assign power_good_s = sync_out[2];

	// ----------------------------------------------------------------
	// Bus strobes and reset triggers
	// ----------------------------------------------------------------
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = access & wb_we_i & wb_sel_i[0];
	assign wr_sleep_go = wr & hit(wb_adr_i, `OFF_SLEEP) & wb_dat_i[`SL_GO];
	assign wr_reset = wr & hit(wb_adr_i, `OFF_RESET) & (wb_dat_i[3:0] != 4'h0);
	// Power-good loss in S0 is a global reset; the button is a plain host reset
	assign trig_global = (wr_reset & wb_dat_i[`RC_GLOBAL]) | ~power_good_s;
	assign trig_cycle = trig_global | (wr_reset & wb_dat_i[`RC_CYCLE]);
	assign trig_s5 = wr_reset & wb_dat_i[`RC_S5] & ~trig_global;
	assign any_trig = wr_reset | ~power_good_s | (button_prev_reg & ~button_n);
	// Wake is held off while the battery is low, unless the sleep target is S3
	assign wake_ok = wake_event_i & ~(batt_low & (target_reg != `TGT_S3));
	assign timed_out = (cnt_reg >= ACK_TIMEOUT_CYC - 32'h1);
	assign cycle_done = (cnt_reg >= PWR_CYCLE_CYC - 32'h1);
	assign batt_low_rise = batt_low & ~batt_low_prev_reg;
	assign in_reset_state = (state_reg == ST_ACKW) | (state_reg == ST_CYCLE) | (state_reg == ST_S5);
	assign sx_mgmt_off = (state_reg == ST_SX) & ~mgmt_on_reg;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_S0: begin
				if (any_trig) begin
					state_next = ST_DRAIN;
				end else if (wr_sleep_go) begin
					state_next = ST_SX;
				end
			end
			ST_SX: begin
				if (wake_ok) begin
					state_next = ST_S0;
				end
			end
			ST_DRAIN: begin
				// Memory must be quiet before the platform sees reset
				if (mem_safe_i) begin
					state_next = ST_ACKW;
				end
			end
			ST_ACKW: begin
				if (reset_ack_i) begin
					if (kind_s5_reg) begin
						state_next = ST_S5;
					end else if (kind_cycle_reg) begin
						state_next = ST_CYCLE;
					end else begin
						state_next = ST_S0;
					end
				end else if (timed_out) begin
					state_next = ST_CYCLE;
				end
			end
			ST_CYCLE: begin
				if (cycle_done) begin
					state_next = ST_S0;
				end
			end
			ST_S5: begin
				if (wake_ok) begin
					state_next = ST_S0;
				end
			end
			default: begin
				state_next = ST_S0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_SX;
			cnt_reg <= 32'h0;
			target_reg <= `TGT_RESET;
			mgmt_on_reg <= 1'b0;
			kind_cycle_reg <= 1'b0;
			kind_s5_reg <= 1'b0;
			in_g3_reg <= 1'b1;
			timeout_reg <= 1'b0;
			batt_low_prev_reg <= 1'b0;
			button_prev_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			batt_low_prev_reg <= batt_low;
			button_prev_reg <= button_n;
			// Counter restarts on every state change
			if (state_next != state_reg) begin
				cnt_reg <= 32'h0;
			end else begin
				cnt_reg <= cnt_reg + 32'h1;
			end
			if (state_reg == ST_S0 && any_trig) begin
				kind_cycle_reg <= trig_cycle;
				kind_s5_reg <= trig_s5;
			end else if (state_reg == ST_ACKW && !reset_ack_i && timed_out) begin
				kind_cycle_reg <= 1'b1;
				kind_s5_reg <= 1'b0;
			end
			if (state_reg == ST_S0 && !any_trig && wr_sleep_go) begin
				target_reg <= wb_dat_i[`SL_TGT_HI:`SL_TGT_LO];
				mgmt_on_reg <= wb_dat_i[`SL_MGMT_ON];
			end
			if (state_next == ST_S0) begin
				in_g3_reg <= 1'b0;
			end
			// Timeout flag: escalation wins over a clear in the same cycle
			if (state_reg == ST_ACKW && !reset_ack_i && timed_out) begin
				timeout_reg <= 1'b1;
			end else if (wr && hit(wb_adr_i, `OFF_STATUS) && wb_dat_i[`ST_TIMEOUT]) begin
				timeout_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Policy bits live in the RTC well; primary reset leaves them alone
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (!rtc_well_reset_n_i) begin
			policy_reg <= `POL_RESET;
		end else if (wr && hit(wb_adr_i, `OFF_POLICY)) begin
			policy_reg <= wb_dat_i[`POL_WIDTH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Management settings: cleared by primary reset, every power-cycle reset and coin-cell loss
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			mgmt_reg <= `MG_RESET;
		end else if (!rtc_well_reset_n_i && !secondary_rtc_reset_n_i) begin
			mgmt_reg <= `MG_RESET;
		end else if (state_reg == ST_CYCLE && kind_cycle_reg && cnt_reg == 32'h0) begin
			mgmt_reg <= `MG_RESET;
		end else if (wr && hit(wb_adr_i, `OFF_MGMT)) begin
			mgmt_reg <= wb_dat_i[`MG_WIDTH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Battery-low interrupt, set wins over a write-one clear
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			smi_reg <= 1'b0;
			system_mgmt_interrupt_o <= 1'b0;
		end else begin
			if (batt_low_rise && state_reg == ST_S0) begin
				smi_reg <= 1'b1;
			end else if (wr && hit(wb_adr_i, `OFF_STATUS) && wb_dat_i[`ST_SMI]) begin
				smi_reg <= 1'b0;
			end
			system_mgmt_interrupt_o <= smi_reg;
		end
	end

	// ----------------------------------------------------------------
	// Sleep outputs and PHY power gates (1 = rail on)
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			sleep_s3_out_n_o <= 1'b0;
			sleep_s4_out_n_o <= 1'b0;
			sleep_s5_out_n_o <= 1'b0;
			mgmt_sleep_out_n_o <= 1'b0;
			wired_phy_power_gate_n_o <= 1'b0;
			wireless_phy_power_gate_n_o <= 1'b0;
		end else begin
			case (state_reg)
				ST_S0, ST_DRAIN, ST_ACKW: begin
					sleep_s3_out_n_o <= 1'b1;
					sleep_s4_out_n_o <= 1'b1;
					sleep_s5_out_n_o <= 1'b1;
					mgmt_sleep_out_n_o <= 1'b1;
					wired_phy_power_gate_n_o <= 1'b1;
					wireless_phy_power_gate_n_o <= 1'b1;
				end
				ST_SX: begin
					sleep_s3_out_n_o <= 1'b0;
					sleep_s4_out_n_o <= (target_reg == `TGT_S3);
					sleep_s5_out_n_o <= (target_reg != `TGT_S5);
					mgmt_sleep_out_n_o <= mgmt_on_reg;
					// Mgmt keep overrides the battery cut; G3 exit keeps PHY if asked
					wired_phy_power_gate_n_o <= mgmt_on_reg
						| (in_g3_reg & policy_reg[`POL_AFTER_G3])
						| mgmt_reg[`MG_LAN_KEEP]
						| (policy_reg[`POL_SLEEP_LAN]
						& ~(policy_reg[`POL_BATT_DIS] & on_battery_i));
					wireless_phy_power_gate_n_o <= (mgmt_reg[`MG_WL_ACCESS] & mgmt_on_reg)
						| (policy_reg[`POL_HOST_WW] & (target_reg != `TGT_S3));
				end
				default: begin
					// Power cycle and straight-to-S5: every gated well off
					sleep_s3_out_n_o <= 1'b0;
					sleep_s4_out_n_o <= 1'b0;
					sleep_s5_out_n_o <= 1'b0;
					mgmt_sleep_out_n_o <= 1'b0;
					wired_phy_power_gate_n_o <= 1'b0;
					wireless_phy_power_gate_n_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Acknowledge value, deep idle gate, memory flush request
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_value_reg <= 1'b0;
			deep_idle_gate_n_o <= 1'b1;
			mem_flush_req_o <= 1'b0;
		end else begin
			// Zero in S0, Sx with mgmt up and all resets but the S5 hold
			if (sx_mgmt_off || state_reg == ST_S5) begin
				ack_value_reg <= on_battery_i ? mgmt_reg[`MG_ACK_DC] : mgmt_reg[`MG_ACK_AC];
			end else begin
				ack_value_reg <= 1'b0;
			end
			deep_idle_gate_n_o <= in_reset_state | ~proc_c10_entry_i;
			mem_flush_req_o <= (state_reg == ST_DRAIN);
		end
	end

	// ----------------------------------------------------------------
	// Platform reset: power-good loss acts at once, without the clock
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge platform_power_good_i) begin
		if (!platform_power_good_i) begin
			platform_reset_n_o <= 1'b0;
		end else if (rst_i) begin
			platform_reset_n_o <= 1'b0;
		end else begin
			platform_reset_n_o <= ~in_reset_state & (state_next != ST_ACKW);
		end
	end

	shared_pin_mux u_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.gpio_mode_i(policy_reg[`POL_GPIO_MODE]),
		.gpio_direction_select_i(policy_reg[`POL_GPIO_DIR]),
		.gpio_data_i(policy_reg[`POL_GPIO_DATA]),
		.native_value_i(ack_value_reg),
		.pin_o(shared_gpio_pin_o),
		.pin_oe_o(shared_gpio_pin_oe_o)
	);

	// ----------------------------------------------------------------
	// Read multiplexer; unmapped offsets read zero
	// ----------------------------------------------------------------
	always @* begin
		rd_data = 32'h0;
		if (hit(wb_adr_i, `OFF_POLICY)) begin
			rd_data[`POL_WIDTH-1:0] = policy_reg;
		end else if (hit(wb_adr_i, `OFF_MGMT)) begin
			rd_data[`MG_WIDTH-1:0] = mgmt_reg;
		end else if (hit(wb_adr_i, `OFF_SLEEP)) begin
			rd_data[`SL_TGT_HI:`SL_TGT_LO] = target_reg;
			rd_data[`SL_MGMT_ON] = mgmt_on_reg;
		end else if (hit(wb_adr_i, `OFF_STATUS)) begin
			rd_data[`ST_STATE_HI:`ST_STATE_LO] = state_reg;
			rd_data[`ST_BATT_LOW] = batt_low;
			rd_data[`ST_SMI] = smi_reg;
			rd_data[`ST_TIMEOUT] = timeout_reg;
			rd_data[`ST_IN_G3] = in_g3_reg;
			rd_data[`ST_GPIO_IN] = shared_gpio_pin_i;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave: one wait state, every access acknowledged
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= access;
			if (access && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end
		end
	end

endmodule
`default_nettype wire

/* File: verification/power_seq_asserts.sv */
// Concurrent checks on the ports of the sideband power sequencer
`timescale 1ns/100ps
`default_nettype none
module power_seq_asserts #(
	parameter [31:0] ACK_TIMEOUT_CYC = 32'd50
) (
	input wire clk_i,
	input wire rst_i,
	input wire battery_low_n_i,
	input wire platform_power_good_i,
	input wire proc_c10_entry_i,
	input wire mem_safe_i,
	input wire sleep_s3_out_n_o,
	input wire mgmt_sleep_out_n_o,
	input wire wired_phy_power_gate_n_o,
	input wire wireless_phy_power_gate_n_o,
	input wire deep_idle_gate_n_o,
	input wire platform_reset_n_o,
	input wire system_mgmt_interrupt_o,
	input wire mem_flush_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Acknowledge wait length
	// ----------------------------------------------------------------
	// Margin covers the power-good path, which reaches the wait late
	logic [31:0] wait_reg;
	always @(posedge clk_i) begin
		if (rst_i || platform_reset_n_o || !sleep_s3_out_n_o)
			wait_reg <= 32'h0;
		else
			wait_reg <= wait_reg + 32'h1;
	end
	sequence batt_fall;
		$fell(battery_low_n_i);
	endsequence
	sequence no_smi_rise;
		!$rose(system_mgmt_interrupt_o);
	endsequence
	AST_WIRED_ON: assert property (sleep_s3_out_n_o || mgmt_sleep_out_n_o |->
		wired_phy_power_gate_n_o) else $error("wired gate low while host or mgmt up");
	AST_WIRELESS_ON: assert property (sleep_s3_out_n_o |-> wireless_phy_power_gate_n_o)
		else $error("wireless gate low while host up");
	AST_PWRGOOD: assert property (!platform_power_good_i |-> !platform_reset_n_o)
		else $error("platform reset not held on power loss");
	AST_DRAIN: assert property ($fell(platform_reset_n_o) && mem_flush_req_o |->
		$past(mem_safe_i)) else $error("platform reset before memory safe");
	AST_C10: assert property (proc_c10_entry_i && platform_reset_n_o |=>
		!deep_idle_gate_n_o || !platform_reset_n_o) else $error("deep idle gate missed");
	AST_RESET_IDLE: assert property (!platform_reset_n_o ##1 !platform_reset_n_o |->
		deep_idle_gate_n_o) else $error("deep idle gate active under reset");
	AST_SMI_SYNC: assert property (batt_fall |-> no_smi_rise ##1 no_smi_rise)
		else $error("interrupt ahead of synchroniser");
	AST_SMI_RUN: assert property (batt_fall ##0 (platform_reset_n_o && sleep_s3_out_n_o
		&& !system_mgmt_interrupt_o) |-> ##[1:6] system_mgmt_interrupt_o)
		else $error("no interrupt on low battery in run");
	AST_ACK_WAIT: assert property (wait_reg <= ACK_TIMEOUT_CYC + 32'd16)
		else $error("acknowledge wait not escalated");
endmodule
`default_nettype wire

/* File: verification/platform_model.sv */
// Platform side model: memory drain answer and reset acknowledge
`timescale 1ns/100ps
`default_nettype none
module platform_model (
	input wire logic clk_i,
	input wire logic mem_flush_req_i,
	input wire logic platform_reset_n_i,
	input wire logic hold_ack_i,
	input wire logic slow_i,
	output logic mem_safe_o,
	output logic reset_ack_o
);
	logic [3:0] flush_cnt_reg;
	logic [3:0] ack_cnt_reg;
	logic acked_reg;
	initial begin
		flush_cnt_reg = 4'h0;
		ack_cnt_reg = 4'h0;
		acked_reg = 1'b0;
		mem_safe_o = 1'b0;
		reset_ack_o = 1'b0;
	end
	// Memory reports safe only after the drain request stood a while
	always @(posedge clk_i) begin
		flush_cnt_reg <= mem_flush_req_i ? flush_cnt_reg + 4'h1 : 4'h0;
		mem_safe_o <= mem_flush_req_i && flush_cnt_reg >= (slow_i ? 4'h4 : 4'h0);
	end
	// One pulse per platform reset; silence forces the escalation path
	always @(posedge clk_i) begin
		if (platform_reset_n_i) begin
			ack_cnt_reg <= 4'h0;
			acked_reg <= 1'b0;
			reset_ack_o <= 1'b0;
		end else begin
			ack_cnt_reg <= ack_cnt_reg + 4'h1;
			reset_ack_o <= !acked_reg && !hold_ack_i && ack_cnt_reg == (slow_i ? 4'h6 : 4'h1);
			if (reset_ack_o)
				acked_reg <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/sideband_power_pins_and_reset_bench.sv */
// Self-checking bench for the sideband power sequencer
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_defines.vh"
module sideband_power_pins_and_reset_bench;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, battery_low_n_i, platform_power_good_i;
	logic system_reset_button_n_i, rtc_well_reset_n_i, secondary_rtc_reset_n_i, on_battery_i;
	logic wake_event_i, proc_c10_entry_i, hold_ack, slow, mon, ob;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, pol, mg;
	logic [1:0] tg;
	wire logic [31:0] wb_dat_o;
	wire logic wb_ack_o, mem_safe_i, reset_ack_i, shared_gpio_pin_i, sleep_s3_out_n_o;
	wire logic sleep_s4_out_n_o, sleep_s5_out_n_o, mgmt_sleep_out_n_o, wired_phy_power_gate_n_o;
	wire logic wireless_phy_power_gate_n_o, deep_idle_gate_n_o, platform_reset_n_o;
	wire logic system_mgmt_interrupt_o, mem_flush_req_o, shared_gpio_pin_o, shared_gpio_pin_oe_o;
	logic [31:0] expq[$];
	int checks = 0;
	int miscompares = 0;
	// Undriven pin shows the inverse so a float is never read as a value
	assign shared_gpio_pin_i = shared_gpio_pin_oe_o ? shared_gpio_pin_o : !shared_gpio_pin_o;
	power_seq #(.ACK_TIMEOUT_CYC(32'd50), .PWR_CYCLE_CYC(32'd20)) i_dut (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.battery_low_n_i, .platform_power_good_i, .system_reset_button_n_i, .rtc_well_reset_n_i,
		.secondary_rtc_reset_n_i, .on_battery_i, .wake_event_i, .proc_c10_entry_i, .mem_safe_i,
		.reset_ack_i, .shared_gpio_pin_i, .sleep_s3_out_n_o, .sleep_s4_out_n_o, .sleep_s5_out_n_o,
		.mgmt_sleep_out_n_o, .wired_phy_power_gate_n_o, .wireless_phy_power_gate_n_o,
		.deep_idle_gate_n_o, .platform_reset_n_o, .system_mgmt_interrupt_o, .mem_flush_req_o,
		.shared_gpio_pin_o, .shared_gpio_pin_oe_o);
	platform_model i_plat (.clk_i, .mem_flush_req_i(mem_flush_req_o),
		.platform_reset_n_i(platform_reset_n_o), .hold_ack_i(hold_ack), .slow_i(slow),
		.mem_safe_o(mem_safe_i), .reset_ack_o(reset_ack_i));
	// ----------------------------------------------------------------
	// Checking, bus cycles and bounded waits
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic give_up;
		miscompares++;
		summarize();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Request held until ack is sampled, then dropped for a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
			n++;
			if (n > 20)
				give_up();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	task automatic wait_prst(input logic v);
		int n;
		n = 0;
		while (platform_reset_n_o !== v) begin
			@(posedge clk_i);
			n++;
			if (n > 300)
				give_up();
		end
	endtask
	// Oldest noted read value against the data that comes with ack
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check("read data", wb_dat_o, expq.pop_front());
	end
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, platform_power_good_i, system_reset_button_n_i, battery_low_n_i} = 4'hF;
		{wb_cyc_i, wb_stb_i, wb_we_i, on_battery_i, wake_event_i, proc_c10_entry_i} = 6'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, hold_ack, slow} = 46'h0F00000000;
		rtc_well_reset_n_i = 1'b0;
		secondary_rtc_reset_n_i = 1'b0;
		void'($urandom(55));
		tick(8);
		rst_i <= 1'b0;
		rtc_well_reset_n_i <= 1'b1;
		secondary_rtc_reset_n_i <= 1'b1;
		rd(`OFF_POLICY, 32'h0);
		rd(`OFF_MGMT, 32'h0);
		rd(8'h20, 32'h0);
		wb(1'b1, `OFF_POLICY, 32'h1);
		tick(3);
		check("after g3 gate", wired_phy_power_gate_n_o, 1'b1);
		wake_event_i <= 1'b1;
		tick(1);
		wake_event_i <= 1'b0;
		tick(4);
		check("run gates", {sleep_s3_out_n_o, mgmt_sleep_out_n_o, wired_phy_power_gate_n_o,
			wireless_phy_power_gate_n_o, platform_reset_n_o}, 5'h1F);
		battery_low_n_i <= 1'b0;
		tick(8);
		check("interrupt", system_mgmt_interrupt_o, 1'b1);
		rd(`OFF_STATUS, 32'hC1);
		wb(1'b1, `OFF_STATUS, 32'h80);
		battery_low_n_i <= 1'b1;
		tick(4);
		check("interrupt clear", system_mgmt_interrupt_o, 1'b0);
		for (int i = 0; i < 3; i++) begin
			pol = $urandom & 32'hF;
			mg = $urandom & 32'hF;
			mon = $urandom;
			ob = $urandom;
			tg = 2'(2 - i);
			on_battery_i <= ob;
			wb(1'b1, `OFF_POLICY, pol);
			wb(1'b1, `OFF_MGMT, mg);
			wb(1'b1, `OFF_SLEEP, {28'h0, 1'b1, mon, tg});
			// Low battery must pass the synchroniser before the wake arrives
			if (i == 0)
				battery_low_n_i <= 1'b0;
			tick(4);
			check("sleep gates", {sleep_s3_out_n_o, sleep_s4_out_n_o, sleep_s5_out_n_o,
				mgmt_sleep_out_n_o, wired_phy_power_gate_n_o, wireless_phy_power_gate_n_o},
				{1'b0, tg == 2'h0, tg != 2'h2, mon, mon | mg[1] | pol[1] & !(pol[2] & ob),
				mg[0] & mon | pol[3] & (tg != 2'h0)});
			check("native ack", {shared_gpio_pin_o, shared_gpio_pin_oe_o},
				{!mon & (ob ? mg[3] : mg[2]), 1'b1});
			wake_event_i <= 1'b1;
			tick(6);
			check("wake block", sleep_s3_out_n_o, i != 0);
			battery_low_n_i <= 1'b1;
			tick(6);
			wake_event_i <= 1'b0;
			tick(3);
		end
		wb(1'b1, `OFF_POLICY, 32'h30);
		tick(4);
		check("gpio input", shared_gpio_pin_oe_o, 1'b0);
		wb(1'b1, `OFF_POLICY, 32'h50);
		tick(4);
		check("gpio output", {shared_gpio_pin_o, shared_gpio_pin_oe_o}, 2'b11);
		wb(1'b1, `OFF_POLICY, 32'h0);
		proc_c10_entry_i <= 1'b1;
		tick(2);
		check("c10 gate", deep_idle_gate_n_o, 1'b0);
		proc_c10_entry_i <= 1'b0;
		on_battery_i <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			slow <= k[0];
			wb(1'b1, `OFF_MGMT, 32'h4);
			wb(1'b1, `OFF_RESET, 32'h1 << k);
			wait_prst(1'b0);
			tick(2);
			check("reset ack pin", shared_gpio_pin_o, 1'b0);
			if (k == 3) begin
				// Slow acknowledge: the hold state is reached only after it
				tick(10);
				check("s5 hold", {sleep_s3_out_n_o, sleep_s5_out_n_o, mgmt_sleep_out_n_o,
					wired_phy_power_gate_n_o, shared_gpio_pin_o}, 5'h01);
				wake_event_i <= 1'b1;
				tick(1);
				wake_event_i <= 1'b0;
			end
			wait_prst(1'b1);
			rd(`OFF_MGMT, (k == 1 || k == 2) ? 32'h0 : 32'h4);
		end
		// Button press is a host reset; no acknowledge forces escalation
		hold_ack <= 1'b1;
		system_reset_button_n_i <= 1'b0;
		wait_prst(1'b0);
		wait_prst(1'b1);
		hold_ack <= 1'b0;
		system_reset_button_n_i <= 1'b1;
		rd(`OFF_STATUS, 32'h101);
		rd(`OFF_MGMT, 32'h0);
		@(posedge clk_i);
		platform_power_good_i <= 1'b0;
		#1;
		check("async reset", platform_reset_n_o, 1'b0);
		tick(3);
		platform_power_good_i <= 1'b1;
		wait_prst(1'b1);
		summarize();
	end
endmodule
bind power_seq power_seq_asserts #(.ACK_TIMEOUT_CYC(ACK_TIMEOUT_CYC)) i_chk (.clk_i, .rst_i,
	.battery_low_n_i, .platform_power_good_i, .proc_c10_entry_i, .mem_safe_i, .sleep_s3_out_n_o,
	.mgmt_sleep_out_n_o, .wired_phy_power_gate_n_o, .wireless_phy_power_gate_n_o,
	.deep_idle_gate_n_o, .platform_reset_n_o, .system_mgmt_interrupt_o, .mem_flush_req_o);
`default_nettype wire
